/* core/can_bit_timer.sv */
// Quantum and segment counter that places the sample point and votes the bus level.
module can_bit_timer (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Timing settings
  input  wire logic       hold,
  input  wire logic [9:0] prescaler,
  input  wire logic [3:0] seg1,
  input  wire logic [2:0] seg2,
  input  wire logic       triple,
  // Synchronised receive level
  input  wire logic       rx_sync,
  // Bit events
  output logic            sample_pulse,
  output logic            bit_value,
  output logic            bit_end
);
  logic [9:0]       tq_r;
  logic [9:0]       tq_nxt;
  logic [3:0]       q_r;
  logic [3:0]       q_nxt;
  can_cfg_pkg::seg_t seg_r;
  can_cfg_pkg::seg_t seg_nxt;
  logic [1:0]       hist_r;
  logic [1:0]       hist_nxt;
  logic             smp_nxt;
  logic             val_nxt;
  logic             end_nxt;
  logic             tq_end;

  function automatic logic majority(input logic a, input logic b, input logic c);
    majority = (a & b) | (a & c) | (b & c);
  endfunction : majority

  // One quantum spans prescaler plus one clocks; segments run sync, one, two.
  always_comb
  begin
    tq_end   = (tq_r == prescaler);
    tq_nxt   = tq_end ? 10'h000 : tq_r + 10'h001;
    q_nxt    = q_r;
    seg_nxt  = seg_r;
    hist_nxt = {hist_r[0], rx_sync};
    if (tq_end)
    begin
      case (seg_r)
        can_cfg_pkg::SEG_SYNC:
        begin
          seg_nxt = can_cfg_pkg::SEG_ONE;
          q_nxt   = 4'h0;
        end
        can_cfg_pkg::SEG_ONE:
        begin
          seg_nxt = (q_r == seg1) ? can_cfg_pkg::SEG_TWO : can_cfg_pkg::SEG_ONE;
          q_nxt   = (q_r == seg1) ? 4'h0 : q_r + 4'h1;
        end
        can_cfg_pkg::SEG_TWO:
        begin
          seg_nxt = (q_r == {1'b0, seg2}) ? can_cfg_pkg::SEG_SYNC : can_cfg_pkg::SEG_TWO;
          q_nxt   = (q_r == {1'b0, seg2}) ? 4'h0 : q_r + 4'h1;
        end
        default:
        begin
          seg_nxt = can_cfg_pkg::SEG_SYNC;
          q_nxt   = 4'h0;
        end
      endcase
    end
    smp_nxt = tq_end && (seg_r == can_cfg_pkg::SEG_ONE) && (q_r == seg1);
    val_nxt = triple ? majority(hist_r[1], hist_r[0], rx_sync) : rx_sync;
    end_nxt = tq_end && (seg_r == can_cfg_pkg::SEG_TWO) && (q_r == {1'b0, seg2});
    if (hold)
    begin
      tq_nxt  = 10'h000;
      q_nxt   = 4'h0;
      seg_nxt = can_cfg_pkg::SEG_SYNC;
      smp_nxt = 1'b0;
      end_nxt = 1'b0;
    end
  end

  // Counters and bit events; the three votes are the last three clocks of segment one.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tq_r         <= 10'h000;
      q_r          <= 4'h0;
      seg_r        <= can_cfg_pkg::SEG_SYNC;
      hist_r       <= 2'b11;
      sample_pulse <= 1'b0;
      bit_value    <= 1'b1;
      bit_end      <= 1'b0;
    end
    else
    begin
      tq_r         <= tq_nxt;
      q_r          <= q_nxt;
      seg_r        <= seg_nxt;
      hist_r       <= hist_nxt;
      sample_pulse <= smp_nxt;
      bit_value    <= smp_nxt ? val_nxt : bit_value;
      bit_end      <= end_nxt;
    end
  end

  // When the two earlier votes are recessive, the triple-sampled bit must be recessive.
  vote_major_a : assert property (@(posedge pclk) disable iff (!presetn)
    (smp_nxt && triple && hist_r == 2'b11) |=> bit_value)
    else $error("Triple sample majority wrong.");

  // A single sample must carry the current level.
  single_smp_a : assert property (@(posedge pclk) disable iff (!presetn)
    (smp_nxt && !triple) |=> (bit_value == $past(rx_sync)))
    else $error("Single sample value wrong.");
endmodule : can_bit_timer

/* core/can_bit_timing_config_ctrl.sv */
// CAN configuration handshake, bit timing registers, acceptance masks and interrupts.
//
// Implementation choices: the APB interface to the registers and the register addresses.
module can_bit_timing_config_ctrl #(
  parameter int MAILBOXES = can_cfg_pkg::MAILBOXES
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // CAN pins
  input  wire logic        rx_pin,
  output logic             tx_pin,
  // Frame engine side
  input  wire logic        tx_bit,
  input  wire logic        rx_event,
  input  wire logic        tx_event,
  input  wire logic        err_event,
  output logic             rx_bit,
  output logic             rx_valid,
  output logic             bus_on,
  // Interrupt requests
  output logic             irq,
  output logic             rx_irq,
  output logic             tx_irq,
  output logic             err_irq,
  output logic      [3:0]  rx_prio,
  output logic      [3:0]  tx_prio,
  output logic      [3:0]  err_prio
);
  // The mask decode uses four index bits, so more than sixteen boxes cannot be reached.
  if (MAILBOXES < 1 || MAILBOXES > 16)
  begin : g_mailbox_check
    $error("MAILBOXES must be between 1 and 16.");
  end
  can_cfg_pkg::mode_t state_r, state_nxt;
  logic              req_r, req_nxt;
  logic              bus_on_nxt;
  logic [9:0]        cfg0_r, cfg0_nxt;
  logic [9:0]        cfg1_r, cfg1_nxt;
  logic [15:0]       prio_r, prio_nxt;
  logic [2:0]        ist_r, ist_nxt;
  logic [2:0]        imask_r, imask_nxt;
  logic [15:0]       mhi_r [MAILBOXES], mhi_nxt [MAILBOXES];
  logic [15:0]       mlo_r [MAILBOXES], mlo_nxt [MAILBOXES];
  logic [31:0]       rdata_nxt;
  logic              err_nxt;
  logic              wr;
  logic              setup;
  logic              rx_meta_r, rx_sync_r;
  logic              sample_pulse;
  logic              bit_value;
  logic              bit_end;
  logic              idle_seen;
  logic [2:0]        events;

  // Mask area decode is shared by the read mux and the write path.
  function automatic logic mask_hit(input logic [11:0] a, input int boxes);
    mask_hit = (a[11:7] == can_cfg_pkg::MASK_AREA_TAG) && (int'(a[6:3]) < boxes);
  endfunction : mask_hit

  function automatic logic known_addr(input logic [11:0] a, input int boxes);
    known_addr = (a[1:0] == 2'b00) && (mask_hit(a, boxes) ||
                 a == can_cfg_pkg::ADDR_MOD_CTRL || a == can_cfg_pkg::ADDR_GLB_STAT ||
                 a == can_cfg_pkg::ADDR_BIT_CFG0 || a == can_cfg_pkg::ADDR_BIT_CFG1 ||
                 a == can_cfg_pkg::ADDR_PRIO7 || a == can_cfg_pkg::ADDR_IRQ_STAT ||
                 a == can_cfg_pkg::ADDR_IRQ_MASK);
  endfunction : known_addr

  // The receive pin comes from outside and passes two flip-flops first.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_meta_r <= 1'b1;
      rx_sync_r <= 1'b1;
    end
    else
    begin
      rx_meta_r <= rx_pin;
      rx_sync_r <= rx_meta_r;
    end
  end

  // Timing is frozen in configuration mode so new settings start a clean bit.
  can_bit_timer u_timer (
    .pclk         (pclk),
    .presetn      (presetn),
    .hold         (state_r == can_cfg_pkg::ST_CFG),
    .prescaler    (cfg0_r[can_cfg_pkg::PRESC_LSB +: can_cfg_pkg::PRESC_W]),
    .seg1         (cfg1_r[can_cfg_pkg::SEG1_LSB +: can_cfg_pkg::SEG1_W]),
    .seg2         (cfg1_r[can_cfg_pkg::SEG2_LSB +: can_cfg_pkg::SEG2_W]),
    .triple       (cfg1_r[can_cfg_pkg::TRIPLE_BIT]),
    .rx_sync      (rx_sync_r),
    .sample_pulse (sample_pulse),
    .bit_value    (bit_value),
    .bit_end      (bit_end)
  );

  // The idle count only runs while waiting to join the bus.
  can_idle_detect u_idle (
    .pclk         (pclk),
    .presetn      (presetn),
    .restart      (state_r != can_cfg_pkg::ST_IDLE_WAIT),
    .sample_pulse (sample_pulse),
    .bit_value    (bit_value),
    .idle_seen    (idle_seen)
  );

  assign setup = psel && !penable;
  assign wr    = psel && penable && pwrite && pready && !pslverr;

  // Mode sequencer; entry waits for the bit in flight to finish when on the bus.
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      can_cfg_pkg::ST_IDLE_WAIT:
      begin
        if (req_r)
          state_nxt = can_cfg_pkg::ST_ENTER;
        else if (idle_seen)
          state_nxt = can_cfg_pkg::ST_RUN;
      end
      can_cfg_pkg::ST_RUN:
      begin
        if (req_r)
          state_nxt = can_cfg_pkg::ST_ENTER;
      end
      can_cfg_pkg::ST_ENTER:
      begin
        if (!bus_on || bit_end)
          state_nxt = can_cfg_pkg::ST_CFG;
      end
      can_cfg_pkg::ST_CFG:
      begin
        if (!req_r)
          state_nxt = can_cfg_pkg::ST_IDLE_WAIT;
      end
      default:
        state_nxt = can_cfg_pkg::ST_IDLE_WAIT;
    endcase
    bus_on_nxt = (state_nxt == can_cfg_pkg::ST_RUN) ||
                 (state_nxt == can_cfg_pkg::ST_ENTER && bus_on);
  end

  // Register write path; timing and masks accept writes only in configuration mode.
  always_comb
  begin
    req_nxt   = req_r;
    cfg0_nxt  = cfg0_r;
    cfg1_nxt  = cfg1_r;
    prio_nxt  = prio_r;
    imask_nxt = imask_r;
    mhi_nxt   = mhi_r;
    mlo_nxt   = mlo_r;
    events    = {err_event, tx_event, rx_event} & {3{bus_on}};
    ist_nxt   = ist_r;
    if (wr)
    begin
      if (paddr == can_cfg_pkg::ADDR_MOD_CTRL)
        req_nxt = pwdata[can_cfg_pkg::REQ_BIT];
      if (paddr == can_cfg_pkg::ADDR_PRIO7)
        prio_nxt = pwdata[15:0];
      if (paddr == can_cfg_pkg::ADDR_IRQ_MASK)
        imask_nxt = pwdata[2:0];
      if (paddr == can_cfg_pkg::ADDR_IRQ_STAT)
        ist_nxt = ist_r & ~pwdata[2:0];
      if (state_r == can_cfg_pkg::ST_CFG)
      begin
        if (paddr == can_cfg_pkg::ADDR_BIT_CFG0)
          cfg0_nxt = pwdata[can_cfg_pkg::PRESC_LSB +: can_cfg_pkg::CFG_W];
        if (paddr == can_cfg_pkg::ADDR_BIT_CFG1)
          cfg1_nxt = pwdata[can_cfg_pkg::CFG_W-1:0];
        if (mask_hit(paddr, MAILBOXES) && paddr[2])
          mlo_nxt[paddr[6:3]] = pwdata[15:0];
        if (mask_hit(paddr, MAILBOXES) && !paddr[2])
          mhi_nxt[paddr[6:3]] = pwdata[15:0];
      end
    end
    // Events win over a clear in the same cycle so none is lost.
    ist_nxt = ist_nxt | events;
  end

  // Read mux and answer; data is captured in setup so the access phase needs no wait.
  always_comb
  begin
    rdata_nxt = 32'h0000_0000;
    case (paddr)
      can_cfg_pkg::ADDR_MOD_CTRL:
        rdata_nxt[can_cfg_pkg::REQ_BIT] = req_nxt;
      can_cfg_pkg::ADDR_GLB_STAT:
      begin
        rdata_nxt[can_cfg_pkg::ACK_BIT]    = (state_r == can_cfg_pkg::ST_CFG);
        rdata_nxt[can_cfg_pkg::BUS_ON_BIT] = bus_on;
      end
      can_cfg_pkg::ADDR_BIT_CFG0:
        rdata_nxt[9:0] = cfg0_r;
      can_cfg_pkg::ADDR_BIT_CFG1:
        rdata_nxt[9:0] = cfg1_r;
      can_cfg_pkg::ADDR_PRIO7:
        rdata_nxt[15:0] = prio_r;
      can_cfg_pkg::ADDR_IRQ_STAT:
        rdata_nxt[2:0] = ist_r;
      can_cfg_pkg::ADDR_IRQ_MASK:
        rdata_nxt[2:0] = imask_r;
      default:
      begin
        if (mask_hit(paddr, MAILBOXES))
          rdata_nxt[15:0] = paddr[2] ? mlo_r[paddr[6:3]] : mhi_r[paddr[6:3]];
      end
    endcase
    err_nxt = setup && !known_addr(paddr, MAILBOXES);
  end

  // Mode, control and bus registers.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_r <= can_cfg_pkg::ST_IDLE_WAIT;
      req_r   <= 1'b0;
      bus_on  <= 1'b0;
      tx_pin  <= 1'b1;
      rx_bit  <= 1'b1;
      rx_valid <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      req_r   <= req_nxt;
      bus_on  <= bus_on_nxt;
      tx_pin  <= bus_on ? tx_bit : 1'b1;
      rx_bit  <= bit_value;
      rx_valid <= sample_pulse && bus_on;
    end
  end

  // Setting registers, masks and the APB answer.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cfg0_r  <= can_cfg_pkg::REG_RESET[9:0];
      cfg1_r  <= can_cfg_pkg::REG_RESET[9:0];
      prio_r  <= can_cfg_pkg::REG_RESET;
      imask_r <= can_cfg_pkg::REG_RESET[2:0];
      for (int i = 0; i < MAILBOXES; i++)
      begin
        mhi_r[i] <= can_cfg_pkg::REG_RESET;
        mlo_r[i] <= can_cfg_pkg::REG_RESET;
      end
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      cfg0_r  <= cfg0_nxt;
      cfg1_r  <= cfg1_nxt;
      prio_r  <= prio_nxt;
      imask_r <= imask_nxt;
      mhi_r   <= mhi_nxt;
      mlo_r   <= mlo_nxt;
      prdata  <= setup ? rdata_nxt : prdata;
      pready  <= setup;
      pslverr <= err_nxt;
    end
  end

  // Sticky status and the request outputs; priorities come straight from their nibbles.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ist_r    <= 3'b000;
      irq      <= 1'b0;
      rx_irq   <= 1'b0;
      tx_irq   <= 1'b0;
      err_irq  <= 1'b0;
      rx_prio  <= 4'h0;
      tx_prio  <= 4'h0;
      err_prio <= 4'h0;
    end
    else
    begin
      ist_r    <= ist_nxt;
      irq      <= |(ist_r & imask_r);
      rx_irq   <= ist_r[can_cfg_pkg::IRQ_RX_BIT] & imask_r[can_cfg_pkg::IRQ_RX_BIT];
      rx_prio  <= prio_nxt[can_cfg_pkg::PRIO_RX_LSB +: can_cfg_pkg::PRIO_W];
      tx_irq   <= ist_r[can_cfg_pkg::IRQ_TX_BIT] & imask_r[can_cfg_pkg::IRQ_TX_BIT];
      tx_prio  <= prio_nxt[can_cfg_pkg::PRIO_TX_LSB +: can_cfg_pkg::PRIO_W];
      err_irq  <= ist_r[can_cfg_pkg::IRQ_ERR_BIT] & imask_r[can_cfg_pkg::IRQ_ERR_BIT];
      err_prio <= prio_nxt[can_cfg_pkg::PRIO_ERR_LSB +: can_cfg_pkg::PRIO_W];
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence req_written_s;
    wr && paddr == can_cfg_pkg::ADDR_MOD_CTRL && pwdata[can_cfg_pkg::REQ_BIT];
  endsequence

  // Entry ends at once off the bus, or on the bus when the bit in flight ends.
  sequence enter_done_s;
    state_r == can_cfg_pkg::ST_ENTER && (!bus_on || bit_end);
  endsequence

  req_enter_a : assert property (
    (req_written_s and (state_r == can_cfg_pkg::ST_RUN)) |-> ##2 state_r == can_cfg_pkg::ST_ENTER)
    else $error("Request did not start configuration entry.");
  ack_rise_a : assert property (
    enter_done_s |=> (state_r == can_cfg_pkg::ST_CFG) && !bus_on)
    else $error("Acknowledge did not follow entry.");
  ack_fall_a : assert property (
    (state_r == can_cfg_pkg::ST_CFG && !req_r) |=> state_r == can_cfg_pkg::ST_IDLE_WAIT)
    else $error("Acknowledge did not fall after request cleared.");
  bus_join_a : assert property ($rose(bus_on) |-> $past(idle_seen))
    else $error("Bus joined before idle detected.");
  tx_recessive_a : assert property (!bus_on |=> tx_pin)
    else $error("Transmit not recessive off bus.");
  rx_irq_a : assert property ((rx_event && bus_on && imask_r[0]) |-> ##2 rx_irq)
    else $error("Receive request not raised.");
  tx_irq_a : assert property ((tx_event && bus_on && imask_r[1]) |-> ##2 tx_irq)
    else $error("Transmit request not raised.");
  err_irq_a : assert property ((err_event && bus_on && imask_r[2]) |-> ##2 err_irq)
    else $error("Error request not raised.");
  cfg_lock_a : assert property (
    (wr && state_r != can_cfg_pkg::ST_CFG) |=> $stable(cfg1_r) && $stable(cfg0_r))
    else $error("Timing changed outside configuration mode.");
endmodule : can_bit_timing_config_ctrl

/* core/can_cfg_pkg.sv */
// Register map, field layout and state encoding shared by the CAN configuration block.
package can_cfg_pkg;
  // Register byte offsets.
  localparam logic [11:0] ADDR_MOD_CTRL  = 12'h000;
  localparam logic [11:0] ADDR_GLB_STAT  = 12'h004;
  localparam logic [11:0] ADDR_BIT_CFG0  = 12'h008;
  localparam logic [11:0] ADDR_BIT_CFG1  = 12'h00C;
  localparam logic [11:0] ADDR_PRIO7     = 12'h010;
  localparam logic [11:0] ADDR_IRQ_STAT  = 12'h014;
  localparam logic [11:0] ADDR_IRQ_MASK  = 12'h018;
  localparam logic [4:0]  MASK_AREA_TAG  = 5'h02;
  // Control and status bit positions.
  localparam int          REQ_BIT        = 7;
  localparam int          ACK_BIT        = 7;
  localparam int          BUS_ON_BIT     = 0;
  // Bit configuration field positions.
  localparam int          PRESC_LSB      = 0;
  localparam int          PRESC_W        = 10;
  localparam int          SEG1_LSB       = 0;
  localparam int          SEG1_W         = 4;
  localparam int          SEG2_LSB       = 4;
  localparam int          SEG2_W         = 3;
  localparam int          TRIPLE_BIT     = 7;
  localparam int          SJW_LSB        = 8;
  localparam int          SJW_W          = 2;
  localparam int          CFG_W          = 10;
  // Priority nibbles and interrupt bits.
  localparam int          PRIO_RX_LSB    = 0;
  localparam int          PRIO_TX_LSB    = 4;
  localparam int          PRIO_ERR_LSB   = 8;
  localparam int          PRIO_W         = 4;
  localparam int          IRQ_RX_BIT     = 0;
  localparam int          IRQ_TX_BIT     = 1;
  localparam int          IRQ_ERR_BIT    = 2;
  localparam int          IRQ_W          = 3;
  // Reset values and counts.
  localparam logic [15:0] REG_RESET      = 16'h0000;
  localparam logic [3:0]  IDLE_BITS      = 4'hB;
  localparam int          MAILBOXES      = 16;

  typedef enum logic [1:0] {
    ST_IDLE_WAIT = 2'b00,
    ST_RUN       = 2'b01,
    ST_ENTER     = 2'b10,
    ST_CFG       = 2'b11
  } mode_t;

  typedef enum logic [1:0] {
    SEG_SYNC = 2'b00,
    SEG_ONE  = 2'b01,
    SEG_TWO  = 2'b10
  } seg_t;
endpackage : can_cfg_pkg

/* core/can_idle_detect.sv */
// Counter of consecutive recessive bits that tells when the bus is idle.
module can_idle_detect (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Bit stream
  input  wire logic restart,
  input  wire logic sample_pulse,
  input  wire logic bit_value,
  // Result
  output logic      idle_seen
);
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;

  // A dominant bit starts the count over; the count saturates at the idle figure.
  always_comb
  begin
    cnt_nxt = cnt_r;
    if (restart)
      cnt_nxt = 4'h0;
    else if (sample_pulse)
      cnt_nxt = !bit_value ? 4'h0 :
                (cnt_r == can_cfg_pkg::IDLE_BITS) ? cnt_r : cnt_r + 4'h1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_r     <= 4'h0;
      idle_seen <= 1'b0;
    end
    else
    begin
      cnt_r     <= cnt_nxt;
      idle_seen <= (cnt_nxt == can_cfg_pkg::IDLE_BITS);
    end
  end
endmodule : can_idle_detect

/* tb/can_xcvr_model.sv */
// Line transceiver model that loops the transmit pin back and can inject dominant glitches.
module can_xcvr_model (
  // Clock
  input  wire logic pclk,
  // Line side
  input  wire logic tx_pin,
  input  wire logic glitch_en,
  output logic      rx_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] cnt_r = 3'h0;
  // One glitch clock in seven, so no three adjacent clocks ever hold two glitches.
  always @(posedge pclk)
    cnt_r <= (cnt_r == 3'h6) ? 3'h0 : cnt_r + 3'h1;
  // The line is wired-AND: any dominant level wins over recessive.
  assign rx_pin = tx_pin & ~(glitch_en & (cnt_r == 3'h0));
endmodule : can_xcvr_model

/* tb/tb_can_bit_timing_config_ctrl.sv */
// Self-checking bench for the CAN configuration block.
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin errors++; \
  $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module tb_can_bit_timing_config_ctrl;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int BIT_CLKS = (4 + 1) * (1 + (2 + 1) + (1 + 1));
  logic        pclk, presetn, psel, penable, pwrite, tx_bit, rx_event, tx_event, err_event;
  logic        glitch_en, pready, pslverr, rx_pin, tx_pin, rx_bit, rx_valid, bus_on;
  logic        irq, rx_irq, tx_irq, err_irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic [3:0]  rx_prio, tx_prio, err_prio;
  logic [15:0] lfsr = 16'h000D;
  logic [65:0] exp_q[$];
  logic [65:0] e;
  int          errors = 0;
  int          samples_checked = 0;
  int          n;

  can_bit_timing_config_ctrl dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_pin(rx_pin), .tx_pin(tx_pin), .tx_bit(tx_bit), .rx_event(rx_event),
    .tx_event(tx_event), .err_event(err_event), .rx_bit(rx_bit), .rx_valid(rx_valid),
    .bus_on(bus_on), .irq(irq), .rx_irq(rx_irq), .tx_irq(tx_irq), .err_irq(err_irq),
    .rx_prio(rx_prio), .tx_prio(tx_prio), .err_prio(err_prio));
  can_xcvr_model xcvr (.pclk(pclk), .tx_pin(tx_pin), .glitch_en(glitch_en), .rx_pin(rx_pin));

  // Free-running 50 MHz clock.
  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  function automatic logic [15:0] nxt(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : nxt

  task automatic give_verdict();
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict

  task automatic tmo();
    errors++;
    give_verdict();
  endtask : tmo

  // One APB transfer; the request is held until pready is sampled high.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 50 && pready !== 1'b1; k++) @(posedge pclk);
    rdata = prdata;
    psel <= 1'b0; penable <= 1'b0;
    // One idle edge keeps the next call from raising psel again in this time step.
    @(posedge pclk);
    if (k >= 50) tmo();
  endtask : apb

  // A read whose expected answer is queued for the watcher; on error only pslverr counts.
  task automatic rd(input logic [11:0] a, input logic er, input logic [31:0] x);
    logic [32:0] m;
    m = er ? 33'h1_0000_0000 : 33'h1_FFFF_FFFF;
    exp_q.push_back({m, {er, x} & m});
    apb(1'b0, a, 32'h0000_0000);
  endtask : rd

  task automatic poll(input logic v);
    int k;
    for (k = 0; k < 20; k++)
    begin
      apb(1'b0, can_cfg_pkg::ADDR_GLB_STAT, 32'h0000_0000);
      if (rdata[can_cfg_pkg::ACK_BIT] === v) break;
    end
    if (k >= 20) tmo();
  endtask : poll

  // Waits for rx_valid (s=0) or bus_on (s=1); k counts the edges waited.
  task automatic wt(input bit s, input int lim, output int k);
    for (k = 0; k < lim && (s ? bus_on : rx_valid) !== 1'b1; k++) @(posedge pclk);
    if (k >= lim) tmo();
  endtask : wt

  // Watcher takes the oldest note at each completed read and compares it.
  always @(posedge pclk)
    if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0)
    begin
      e = exp_q.pop_front();
      `CHK({pslverr, prdata} & e[65:33], e[32:0])
    end

  // Main sequence: reset, configuration round, timing, sampling, interrupts.
  initial
  begin
    {psel, penable, pwrite, rx_event, tx_event, err_event, glitch_en, presetn} = 8'h00;
    tx_bit = 1'b1;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd(can_cfg_pkg::ADDR_BIT_CFG0, 1'b0, 32'h0000_0000);
    rd(12'h020, 1'b1, 32'h0000_0000);
    rd(12'h002, 1'b1, 32'h0000_0000);
    apb(1'b1, can_cfg_pkg::ADDR_BIT_CFG1, 32'h0000_003F);
    rd(can_cfg_pkg::ADDR_BIT_CFG1, 1'b0, 32'h0000_0000);
    wt(1'b1, 300, n);
    apb(1'b1, can_cfg_pkg::ADDR_MOD_CTRL, 32'h0000_0080);
    poll(1'b1);
    tx_bit <= 1'b0;
    rx_event <= 1'b1;
    @(posedge pclk);
    rx_event <= 1'b0;
    repeat (3) @(posedge pclk);
    `CHK({tx_pin, bus_on}, 2'b10)
    rd(can_cfg_pkg::ADDR_IRQ_STAT, 1'b0, 32'h0000_0000);
    tx_bit <= 1'b1;
    lfsr = nxt(lfsr);
    apb(1'b1, 12'h118, {16'h0000, lfsr});
    rd(12'h118, 1'b0, {16'h0000, lfsr});
    apb(1'b1, can_cfg_pkg::ADDR_BIT_CFG0, 32'h0000_0004);
    apb(1'b1, can_cfg_pkg::ADDR_BIT_CFG1, 32'h0000_0092);
    rd(can_cfg_pkg::ADDR_BIT_CFG1, 1'b0, 32'h0000_0092);
    apb(1'b1, can_cfg_pkg::ADDR_MOD_CTRL, 32'h0000_0000);
    poll(1'b0);
    `CHK(bus_on, 1'b0)
    wt(1'b1, 1000, n);
    `CHK(n >= 290, 1'b1)
    wt(1'b0, 100, n);
    @(posedge pclk);
    wt(1'b0, 100, n);
    `CHK(n + 1, BIT_CLKS)
    // Single-clock glitches must lose the three-sample vote.
    glitch_en <= 1'b1;
    repeat (4)
    begin
      @(posedge pclk);
      wt(1'b0, 100, n);
      `CHK(rx_bit, 1'b1)
    end
    glitch_en <= 1'b0;
    tx_bit <= 1'b0;
    repeat (2) @(posedge pclk);
    `CHK(tx_pin, 1'b0)
    repeat (2)
    begin
      @(posedge pclk);
      wt(1'b0, 100, n);
    end
    `CHK(rx_bit, 1'b0)
    tx_bit <= 1'b1;
    apb(1'b1, can_cfg_pkg::ADDR_IRQ_MASK, 32'h0000_0007);
    lfsr = nxt(lfsr);
    apb(1'b1, can_cfg_pkg::ADDR_PRIO7, {16'h0000, lfsr});
    repeat (2) @(posedge pclk);
    `CHK({err_prio, tx_prio, rx_prio}, lfsr[11:0])
    for (int i = 0; i < 3; i++)
    begin
      {err_event, tx_event, rx_event} <= 3'(1 << i);
      @(posedge pclk);
      {err_event, tx_event, rx_event} <= 3'h0;
      repeat (3) @(posedge pclk);
      `CHK({err_irq, tx_irq, rx_irq, irq}, {3'(1 << i), 1'b1})
      rd(can_cfg_pkg::ADDR_IRQ_STAT, 1'b0, 32'(1 << i));
      apb(1'b1, can_cfg_pkg::ADDR_IRQ_STAT, 32'(1 << i));
      repeat (2) @(posedge pclk);
      `CHK(irq, 1'b0)
    end
    // A masked source keeps its status bit but leaves the line low.
    apb(1'b1, can_cfg_pkg::ADDR_IRQ_MASK, 32'h0000_0000);
    err_event <= 1'b1;
    @(posedge pclk);
    err_event <= 1'b0;
    repeat (3) @(posedge pclk);
    `CHK(irq, 1'b0)
    rd(can_cfg_pkg::ADDR_IRQ_STAT, 1'b0, 32'h0000_0004);
    // Second round from the bus turns triple sampling off; a dominant bit must still be read.
    apb(1'b1, can_cfg_pkg::ADDR_MOD_CTRL, 32'h0000_0080);
    poll(1'b1);
    apb(1'b1, can_cfg_pkg::ADDR_BIT_CFG1, 32'h0000_0012);
    rd(can_cfg_pkg::ADDR_BIT_CFG1, 1'b0, 32'h0000_0012);
    apb(1'b1, can_cfg_pkg::ADDR_MOD_CTRL, 32'h0000_0000);
    poll(1'b0);
    wt(1'b1, 1000, n);
    tx_bit <= 1'b0;
    repeat (2)
    begin
      @(posedge pclk);
      wt(1'b0, 100, n);
    end
    `CHK(rx_bit, 1'b0)
    tx_bit <= 1'b1;
    give_verdict();
  end
endmodule : tb_can_bit_timing_config_ctrl
